/* File: logic/metering_cfg_pkg.sv */
package metering_cfg_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [15:0] SETUP_IDX = 16'hE618;
  localparam logic [15:0] ACCSEL_IDX = 16'hE701;
  localparam logic [31:0] SETUP_ADDR = {14'h0000, SETUP_IDX, 2'h0};
  localparam logic [31:0] ACCSEL_ADDR = {14'h0000, ACCSEL_IDX, 2'h0};

  // measurement_setup fields
  localparam int PERIOD_SEL_LSB = 0;
  localparam int PEAK_SEL_LSB = 2;
  localparam int SETUP_RESV_LSB = 5;
  localparam logic [7:0] SETUP_RESET = 8'h1C;
  localparam logic [7:0] SETUP_WMASK = 8'h1F;

  // accumulation_select fields
  localparam int ACTIVE_MODE_LSB = 0;
  localparam int REACTIVE_MODE_LSB = 2;
  localparam logic [7:0] ACCSEL_RESET = 8'h00;
  localparam logic [7:0] ACCSEL_WMASK = 8'hFF;

  localparam logic [1:0] PERIOD_PHASE_A = 2'h0;
  localparam logic [1:0] PERIOD_PHASE_B = 2'h1;
  localparam logic [1:0] PERIOD_PHASE_C = 2'h2;
  localparam logic [1:0] ACTIVE_SIGNED = 2'h0;
  localparam logic [1:0] ACTIVE_ABSOLUTE = 2'h3;
  localparam logic [1:0] REACTIVE_SIGNED = 2'h0;
  localparam logic [1:0] REACTIVE_BY_ACTIVE = 2'h2;

  localparam int SAMPLE_W = 24;
  localparam int QTY_N = 2;

  typedef enum logic [1:0] {
    ACT_SIGNED,
    ACT_ABS
  } active_mode_e;

  typedef enum logic [1:0] {
    REACT_SIGNED,
    REACT_BY_ACTIVE
  } reactive_mode_e;

  // index 0 total, index 1 fundamental
  typedef struct packed {
    logic [QTY_N-1:0][SAMPLE_W-1:0] active;
    logic [QTY_N-1:0][SAMPLE_W-1:0] reactive;
  } power_sample_s;

endpackage : metering_cfg_pkg

/* File: logic/metering_accum_config.sv */
`timescale 1ns/1ps
// Contract
// R01 - period source 00/01/10 picks phase A/B/C
// R02 - period code 11 acts as phase A
// R03 - setup bits 2,3,4 enable peak phases A,B,C
// R04 - any peak phase combination allowed together
// R05 - every selected phase crossing advances peak window
// R06 - setup bits 7:5 reserved, no effect
// R07 - active mode 00 accumulates signed
// R08 - active codes 01,10 act as signed
// R09 - active mode 11 accumulates absolute
// R10 - reactive mode 00 at bits 3:2 signed
// R11 - reactive code 01 acts as signed
// R12 - reactive mode 10 follows active power sign
// R13 - reactive code 11 acts as signed
// R14 - absolute mode adds magnitude regardless of sign
module metering_accum_config (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] zero_cross,
  input wire logic sample_valid,
  input wire metering_cfg_pkg::power_sample_s sample_in,
  output logic [1:0] line_period_phase_select,
  output logic line_period_zero_cross,
  output logic [2:0] peak_phase_select,
  output logic [1:0] peak_window_advance,
  output logic accum_valid,
  output metering_cfg_pkg::power_sample_s accum_out
);

  localparam int W = metering_cfg_pkg::SAMPLE_W;
  localparam int N = metering_cfg_pkg::QTY_N;
  localparam logic [W-1:0] MAX_POS = {1'b0, {(W-1){1'b1}}};
  localparam logic [W-1:0] MIN_NEG = {1'b1, {(W-1){1'b0}}};

  logic [7:0] setup_reg;
  logic [7:0] setup_next;
  logic [7:0] accsel_reg;
  logic [7:0] accsel_next;
  logic wr_pending_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] hrdata_next;
  logic [1:0] period_sel;
  metering_cfg_pkg::active_mode_e act_mode;
  metering_cfg_pkg::reactive_mode_e react_mode;
  wire metering_cfg_pkg::power_sample_s accum_next;
  logic addr_phase;

  function automatic logic [1:0] period_decode(input logic [1:0] code);
    // reserved 11 falls back to phase a
    if (code == metering_cfg_pkg::PERIOD_PHASE_B)
      return metering_cfg_pkg::PERIOD_PHASE_B;
    else if (code == metering_cfg_pkg::PERIOD_PHASE_C)
      return metering_cfg_pkg::PERIOD_PHASE_C;
    else
      return metering_cfg_pkg::PERIOD_PHASE_A; // R01 R02
  endfunction : period_decode

  function automatic logic [7:0] reg_read(input logic [31:0] addr,
                                          input logic [7:0] setup,
                                          input logic [7:0] accsel);
    if (addr == metering_cfg_pkg::SETUP_ADDR)
      return setup & metering_cfg_pkg::SETUP_WMASK;
    else if (addr == metering_cfg_pkg::ACCSEL_ADDR)
      return accsel;
    else
      return 8'h00;
  endfunction : reg_read

  // saturating negate: the most negative sample has no positive twin
  function automatic logic [W-1:0] neg_sat(input logic [W-1:0] x);
    if (x == MIN_NEG)
      return MAX_POS;
    else
      return W'(-x);
  endfunction : neg_sat

  function automatic logic [W-1:0] abs_sat(input logic [W-1:0] x);
    if (x[W-1])
      return neg_sat(x);
    else
      return x;
  endfunction : abs_sat

  function automatic logic [1:0] count3(input logic [2:0] v);
    return 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction : count3

  // bus slave
  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
    end else if (ce) begin
      if (hready) begin
        wr_pending_reg <= addr_phase && hwrite;
        wr_addr_reg <= haddr;
      end
    end
  end

  always_comb begin
    setup_next = setup_reg;
    accsel_next = accsel_reg;
    if (wr_pending_reg) begin
      if (wr_addr_reg == metering_cfg_pkg::SETUP_ADDR)
        setup_next = hwdata[7:0] & metering_cfg_pkg::SETUP_WMASK; // R06
      else if (wr_addr_reg == metering_cfg_pkg::ACCSEL_ADDR)
        accsel_next = hwdata[7:0] & metering_cfg_pkg::ACCSEL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      setup_reg <= metering_cfg_pkg::SETUP_RESET;
      accsel_reg <= metering_cfg_pkg::ACCSEL_RESET;
    end else if (ce) begin
      setup_reg <= setup_next;
      accsel_reg <= accsel_next;
    end
  end

  // read from the next values so a read right after a write sees it
  always_comb begin
    hrdata_next = 32'h00000000;
    if (addr_phase && !hwrite)
      hrdata_next = {24'h000000, reg_read(haddr, setup_next, accsel_next)};
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      if (hready)
        hrdata <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // mode decode
  assign period_sel = period_decode(
    setup_reg[metering_cfg_pkg::PERIOD_SEL_LSB +: 2]); // R01 R02

  always_comb begin
    // reserved active codes behave as signed
    if (accsel_reg[metering_cfg_pkg::ACTIVE_MODE_LSB +: 2] ==
        metering_cfg_pkg::ACTIVE_ABSOLUTE)
      act_mode = metering_cfg_pkg::ACT_ABS; // R09
    else
      act_mode = metering_cfg_pkg::ACT_SIGNED; // R07 R08
    if (accsel_reg[metering_cfg_pkg::REACTIVE_MODE_LSB +: 2] ==
        metering_cfg_pkg::REACTIVE_BY_ACTIVE)
      react_mode = metering_cfg_pkg::REACT_BY_ACTIVE; // R12
    else
      react_mode = metering_cfg_pkg::REACT_SIGNED; // R10 R11 R13
  end

  // phase selection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_period_phase_select <= metering_cfg_pkg::PERIOD_PHASE_A;
      line_period_zero_cross <= 1'b0;
      peak_phase_select <= metering_cfg_pkg::SETUP_RESET[4:2];
      peak_window_advance <= 2'h0;
    end else if (ce) begin
      line_period_phase_select <= period_sel; // R01 R02
      line_period_zero_cross <= zero_cross[period_sel]; // R01
      // independent enables, any mix at once
      peak_phase_select <=
        setup_reg[metering_cfg_pkg::PEAK_SEL_LSB +: 3]; // R03 R04
      // each selected phase that crosses this cycle adds one to the window advance
      peak_window_advance <= count3(zero_cross &
        setup_reg[metering_cfg_pkg::PEAK_SEL_LSB +: 3]); // R05
    end
  end

  // accumulation conditioning
  for (genvar q = 0; q < N; q++) begin : g_qty
    logic [W-1:0] act_c;
    logic [W-1:0] react_c;
    always_comb begin
      act_c = sample_in.active[q];
      react_c = sample_in.reactive[q];
      unique case (act_mode)
        metering_cfg_pkg::ACT_ABS:
          act_c = abs_sat(sample_in.active[q]); // R09 R14
        metering_cfg_pkg::ACT_SIGNED:
          act_c = sample_in.active[q]; // R07 R08
      endcase
      unique case (react_mode)
        metering_cfg_pkg::REACT_BY_ACTIVE:
          // sign follows the matching active power, zero counts positive
          react_c = sample_in.active[q][W-1] ?
            neg_sat(sample_in.reactive[q]) :
            sample_in.reactive[q]; // R12
        metering_cfg_pkg::REACT_SIGNED:
          react_c = sample_in.reactive[q]; // R10 R11 R13
      endcase
    end
    assign accum_next.active[q] = act_c;
    assign accum_next.reactive[q] = react_c;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      accum_valid <= 1'b0;
      accum_out <= '0;
    end else if (ce) begin
      accum_valid <= sample_valid;
      if (sample_valid)
        accum_out <= accum_next;
    end
  end

  // assertions
  a_period_resv: assert property (@(posedge clk) // R02
    disable iff (!rstn)
    ce && setup_reg[1:0] == 2'h3 |=> line_period_phase_select == 2'h0)
    else $error("reserved period code did not fall back to phase a");

  a_period_cross: assert property (@(posedge clk) // R01
    disable iff (!rstn)
    ce && setup_reg[1:0] == 2'h2 && zero_cross[2] |=> line_period_zero_cross)
    else $error("phase c crossing not passed to period measurement");

  a_period_phase_a: assert property (@(posedge clk) // R01
    disable iff (!rstn)
    ce && setup_reg[1:0] == 2'h0 |=> line_period_phase_select == 2'h0)
    else $error("period code 00 did not pick phase a");

  a_period_phase_b: assert property (@(posedge clk) // R01
    disable iff (!rstn)
    ce && setup_reg[1:0] == 2'h1 |=> line_period_phase_select == 2'h1)
    else $error("period code 01 did not pick phase b");

  a_period_phase_c: assert property (@(posedge clk) // R01
    disable iff (!rstn)
    ce && setup_reg[1:0] == 2'h2 |=> line_period_phase_select == 2'h2)
    else $error("period code 10 did not pick phase c");

  a_resv_cross: assert property (@(posedge clk) // R02
    disable iff (!rstn)
    ce && setup_reg[1:0] == 2'h3 |=>
      line_period_zero_cross == $past(zero_cross[0]))
    else $error("reserved period code did not follow phase a crossing");

  a_peak_enables: assert property (@(posedge clk) // R03 R04
    disable iff (!rstn)
    ce |=> peak_phase_select == $past(setup_reg[4:2]))
    else $error("peak phase enables do not follow setup bits");

  a_peak_advance: assert property (@(posedge clk) // R05
    disable iff (!rstn)
    ce && setup_reg[4:2] == 3'h7 && zero_cross == 3'h7 |=>
      peak_window_advance == 2'h3)
    else $error("peak window did not advance by three");

  a_peak_single: assert property (@(posedge clk) // R05
    disable iff (!rstn)
    ce && setup_reg[4:2] == 3'h2 && zero_cross == 3'h7 |=>
      peak_window_advance == 2'h1)
    else $error("single enabled phase did not advance by one");

  a_peak_none: assert property (@(posedge clk) // R05
    disable iff (!rstn)
    ce && (setup_reg[4:2] & zero_cross) == 3'h0 |=>
      peak_window_advance == 2'h0)
    else $error("peak window advanced without a selected crossing");

  a_setup_resv: assert property (@(posedge clk) // R06
    disable iff (!rstn)
    ce && hsel && hready && htrans[1] && !hwrite &&
      haddr == metering_cfg_pkg::SETUP_ADDR |=> hrdata[7:5] == 3'h0)
    else $error("reserved setup bits read nonzero");

  a_active_signed: assert property (@(posedge clk) // R07 R08
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[1:0] != 2'h3 |=>
      accum_out.active == $past(sample_in.active))
    else $error("signed active sample altered");

  a_active_abs: assert property (@(posedge clk) // R09 R14
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[1:0] == 2'h3 |=>
      !accum_out.active[0][W-1] && !accum_out.active[1][W-1])
    else $error("absolute active sample still negative");

  a_active_keep: assert property (@(posedge clk) // R14
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[1:0] == 2'h3 &&
      !sample_in.active[0][W-1] |=>
      accum_out.active[0] == $past(sample_in.active[0]))
    else $error("absolute mode altered a positive sample");

  a_active_min: assert property (@(posedge clk) // R14
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[1:0] == 2'h3 &&
      sample_in.active[0] == MIN_NEG |=> accum_out.active[0] == MAX_POS)
    else $error("most negative active sample did not saturate");

  a_react_flip: assert property (@(posedge clk) // R12
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[3:2] == 2'h2 &&
      sample_in.active[0][W-1] && sample_in.reactive[0] == W'(5) |=>
      accum_out.reactive[0] == W'(-5))
    else $error("reactive sign not reversed for negative active");

  a_react_keep: assert property (@(posedge clk) // R12
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[3:2] == 2'h2 &&
      !sample_in.active[0][W-1] |=>
      accum_out.reactive[0] == $past(sample_in.reactive[0]))
    else $error("reactive sign changed for positive active");

  a_react_fund: assert property (@(posedge clk) // R12
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[3:2] == 2'h2 &&
      sample_in.active[1][W-1] && !sample_in.reactive[1][W-1] &&
      sample_in.reactive[1] != '0 |=> accum_out.reactive[1][W-1])
    else $error("fundamental reactive sign not reversed");

  a_react_signed: assert property (@(posedge clk) // R10 R11 R13
    disable iff (!rstn)
    ce && sample_valid && accsel_reg[3:2] != 2'h2 |=>
      accum_out.reactive == $past(sample_in.reactive))
    else $error("signed reactive sample altered");

  a_accum_hold: assert property (@(posedge clk)
    disable iff (!rstn)
    ce && !sample_valid |=> $stable(accum_out))
    else $error("conditioned sample changed without a valid");

  a_valid_follow: assert property (@(posedge clk)
    disable iff (!rstn)
    ce |=> accum_valid == $past(sample_valid))
    else $error("sample valid not passed on after one cycle");

  a_bus_okay: assert property (@(posedge clk)
    disable iff (!rstn)
    ce |=> hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  a_freeze: assert property (@(posedge clk)
    disable iff (!rstn)
    !ce |=> $stable(setup_reg) && $stable(accsel_reg) &&
      $stable(peak_window_advance))
    else $error("state moved while the clock enable was low");

endmodule : metering_accum_config

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
  localparam int CW = $bits(metering_cfg_pkg::power_sample_s);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [2:0] hsize = 3'h0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [2:0] zero_cross = 3'h0;
  logic sample_valid = 1'b0;
  metering_cfg_pkg::power_sample_s sample_in = '0;
  metering_cfg_pkg::power_sample_s accum_out;
  metering_cfg_pkg::power_sample_s s;
  logic [1:0] line_period_phase_select;
  logic line_period_zero_cross;
  logic [2:0] peak_phase_select;
  logic [1:0] peak_window_advance;
  logic accum_valid;
  logic [31:0] rd;
  logic [7:0] d;
  logic [2:0] z;
  logic [23:0] corner [4] = '{24'h800000, 24'hFFFFFF, 24'h000001, 24'h000000};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  metering_accum_config i_dut (.clk(clk), .rstn(rstn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .zero_cross(zero_cross),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .line_period_phase_select(line_period_phase_select),
    .line_period_zero_cross(line_period_zero_cross),
    .peak_phase_select(peak_phase_select),
    .peak_window_advance(peak_window_advance),
    .accum_valid(accum_valid), .accum_out(accum_out));

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg,
               seen, exp);
    end
  endtask : check

  // master holds each phase until hready is seen high at an edge
  task automatic bus(input logic [31:0] a, input logic wr,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    check(CW'(hresp), CW'(1'b0), "response");
  endtask : bus

  function automatic logic [23:0] neg(input logic [23:0] v);
    // most negative value saturates instead of wrapping to itself
    return (v == 24'h800000) ? 24'h7FFFFF : (~v + 24'h000001);
  endfunction : neg

  function automatic metering_cfg_pkg::power_sample_s cond(
      input metering_cfg_pkg::power_sample_s x, input logic [7:0] m);
    metering_cfg_pkg::power_sample_s r;
    r = x;
    for (int i = 0; i < 2; i++) begin
      if (m[1:0] == 2'h3 && x.active[i][23]) r.active[i] = neg(x.active[i]);
      if (m[3:2] == 2'h2 && x.active[i][23]) begin
        r.reactive[i] = neg(x.reactive[i]);
      end
    end
    return r;
  endfunction : cond

  task automatic send(input metering_cfg_pkg::power_sample_s x);
    @(posedge clk);
    sample_in <= x;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1;
    check(CW'(accum_valid), CW'(1'b1), "sample valid");
    check(CW'(accum_out), CW'(cond(x, d)), "sample out");
  endtask : send

  initial begin
    void'($urandom(69680));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    bus(metering_cfg_pkg::SETUP_ADDR, 1'b0, 32'h0, rd);
    check(CW'(rd), CW'(32'h0000001C), "setup reset");
    bus(metering_cfg_pkg::ACCSEL_ADDR, 1'b0, 32'h0, rd);
    check(CW'(rd), CW'(32'h00000000), "accsel reset");
    check(CW'(peak_phase_select), CW'(3'h7), "peak reset");
    bus(32'h00000100, 1'b1, 32'h000000FF, rd);
    bus(32'h00000100, 1'b0, 32'h0, rd);
    check(CW'(rd), CW'(32'h0), "unmapped read");
    for (int i = 0; i < 32; i++) begin
      d = {3'($urandom()), 5'(i)};
      bus(metering_cfg_pkg::SETUP_ADDR, 1'b1, {24'h0, d}, rd);
      bus(metering_cfg_pkg::SETUP_ADDR, 1'b0, 32'h0, rd);
      check(CW'(rd), CW'({27'h0, d[4:0]}), "setup readback");
      check(CW'(peak_phase_select), CW'(d[4:2]), "peak select");
      check(CW'(line_period_phase_select),
            CW'((d[1:0] == 2'h3) ? 2'h0 : d[1:0]), "period sel");
      for (int k = 0; k < 3; k++) begin
        z = (k == 0) ? 3'h7 : 3'($urandom());
        @(posedge clk);
        zero_cross <= z;
        @(posedge clk);
        #1;
        z = z & d[4:2];
        check(CW'(peak_window_advance),
              CW'({1'b0, z[0]} + {1'b0, z[1]} + {1'b0, z[2]}), "advance");
        z = zero_cross;
        check(CW'(line_period_zero_cross),
              CW'(z[(d[1:0] == 2'h3) ? 0 : d[1:0]]), "period cross");
      end
    end
    // crossings change while the enable is low: outputs must not move
    @(posedge clk);
    ce <= 1'b0;
    zero_cross <= ~zero_cross;
    repeat (2) @(posedge clk);
    #1;
    check(CW'(line_period_zero_cross),
          CW'(z[(d[1:0] == 2'h3) ? 0 : d[1:0]]), "frozen cross");
    check(CW'(peak_phase_select), CW'(d[4:2]), "frozen peak");
    @(posedge clk);
    ce <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      d = {4'($urandom()), 4'(i)};
      bus(metering_cfg_pkg::ACCSEL_ADDR, 1'b1, {24'h0, d}, rd);
      bus(metering_cfg_pkg::ACCSEL_ADDR, 1'b0, 32'h0, rd);
      check(CW'(rd), CW'({24'h0, d}), "accsel readback");
      for (int k = 0; k < 6; k++) begin
        s = {$urandom(), $urandom(), $urandom()};
        if (k < 4) begin
          s.active[0] = corner[k];
          s.active[1] = corner[3 - k];
          s.reactive[0] = corner[(k + 1) % 4];
        end
        if (k > 3) s.active[0][23] = 1'b1;
        if (k == 4) s.reactive[0] = 24'h000005;
        if (k == 5) s.reactive[0] = 24'h800000;
        send(s);
      end
    end
    complete_run();
  end
endmodule : tb
